//--- hdl/dmcps_regs.svh
// Constants for the memory controller port shell
`ifndef DMCPS_REGS_SVH
`define DMCPS_REGS_SVH
`define DMCPS_APB_IDX_MSB 11
`define DMCPS_APB_IDX_LSB 2
`define DMCPS_RESP_OKAY 2'h0
`define DMCPS_RESP_EXOKAY 2'h1
`define DMCPS_LOCK_EXCL 2'h1
`define DMCPS_ROW_MSB 25
`define DMCPS_ROW_LSB 10
`define DMCPS_REG_SCRATCH 10'h000
`define DMCPS_REG_STATUS 10'h001
`define DMCPS_REG_CTRL 10'h002
`define DMCPS_CMD_NOP 3'h7
`define DMCPS_CMD_ACT 3'h3
`define DMCPS_CMD_RD 3'h5
`define DMCPS_CMD_WR 3'h4
`define DMCPS_CMD_REF 3'h1
`define DMCPS_REFRESH_NS 7800
`define DMCPS_CLK_NS 100
`define DMCPS_REF_CYC (`DMCPS_REFRESH_NS / `DMCPS_CLK_NS)
`endif

//--- hdl/dmcps_pkg.sv
// Types for the memory controller port shell
package dmcps_pkg;
    typedef enum logic [2:0] {
        DMCPS_IDLE = 3'b000,
        DMCPS_ACT = 3'b001,
        DMCPS_RD = 3'b010,
        DMCPS_WR = 3'b011,
        DMCPS_BRESP = 3'b100,
        DMCPS_REF = 3'b101
    } dmcps_state_e;
endpackage

//--- hdl/dmcps_top.sv
// Memory controller port shell: AXI slave, APB port, memory pads
`timescale 1ns/100ps
`include "dmcps_regs.svh"
module dmcps_top import dmcps_pkg::*; #(
    parameter int chip_select_count = 2,
    parameter int memory_bits_wide = 16,
    parameter int axi_tag_width = 4,
    parameter bit use_phy_pads = 1'b0,
    parameter bit cke_per_chip = 1'b1,
    parameter bit mem_is_ddr = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // AXI write address
    input wire logic [31:0] i_awaddr,
    input wire logic [axi_tag_width-1:0] i_awid,
    input wire logic [3:0] i_awlen,
    input wire logic [1:0] i_awlock,
    input wire logic [3:0] i_awcache,
    input wire logic [2:0] i_awprot,
    input wire logic i_awvalid,
    output logic o_awready,
    // AXI write data
    input wire logic [31:0] i_wdata,
    input wire logic [axi_tag_width-1:0] i_wid,
    input wire logic i_wlast,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI write response
    output logic [axi_tag_width-1:0] o_bid,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI read address
    input wire logic [31:0] i_araddr,
    input wire logic [axi_tag_width-1:0] i_arid,
    input wire logic [3:0] i_arlen,
    input wire logic [1:0] i_arlock,
    input wire logic [3:0] i_arcache,
    input wire logic [2:0] i_arprot,
    input wire logic i_arvalid,
    output logic o_arready,
    // AXI read data
    output logic [31:0] o_rdata,
    output logic [axi_tag_width-1:0] o_rid,
    output logic o_rlast,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // AXI low-power
    input wire logic i_csysreq,
    output logic o_csysack,
    output logic o_cactive,
    // APB
    input wire logic [31:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Memory pads (direct pins, or PHY-side when use_phy_pads)
    output logic [15:0] o_add,
    output logic o_auto_precharge_flag,
    output logic [1:0] o_ba,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic [chip_select_count-1:0] o_cs_n,
    output logic [chip_select_count-1:0] o_cke,
    output logic [chip_select_count-1:0] o_clk_out,
    output logic o_data_en,
    output logic [memory_bits_wide/8-1:0] o_dqm,
    output logic [memory_bits_wide-1:0] o_dq_out,
    input wire logic [memory_bits_wide-1:0] i_dq_in,
    input wire logic [memory_bits_wide/8-1:0] i_dqs_in,
    input wire logic [memory_bits_wide/8-1:0] i_dqs_in_n,
    output logic [memory_bits_wide/8-1:0] o_dqs_out
);
    localparam int MB = memory_bits_wide / 8;
    localparam logic [9:0] REF_CYC = 10'(`DMCPS_REF_CYC);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [memory_bits_wide-1:0] dq_s1, dq_s2;
    logic [MB-1:0] dqs_s1, dqs_s2, dqsn_s1, dqsn_s2;
    logic csys_s1, csys_s2;
    // Two flops on the data, strobe and csysreq inputs
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dqs_s1 <= '0;
            dqs_s2 <= '0;
            dqsn_s1 <= '0;
            dqsn_s2 <= '0;
            csys_s1 <= 1'b1;
            csys_s2 <= 1'b1;
        end else begin
            dq_s1 <= i_dq_in;
            dq_s2 <= dq_s1;
            dqs_s1 <= i_dqs_in;
            dqs_s2 <= dqs_s1;
            dqsn_s1 <= i_dqs_in_n;
            dqsn_s2 <= dqsn_s1;
            csys_s1 <= i_csysreq;
            csys_s2 <= csys_s1;
        end
    end

    // ----------------------------------------------------------------
    // AXI engine, one transaction at a time
    // ----------------------------------------------------------------
    dmcps_state_e state, next_state;
    logic [axi_tag_width-1:0] tag, next_tag;
    logic [15:0] row, next_row;
    logic [3:0] beats, next_beats;
    logic excl, next_excl;
    logic [9:0] ref_cnt, next_ref_cnt;
    logic ref_due, next_ref_due;
    logic [31:0] scratch, next_scratch;
    logic lp_en, next_lp_en;
    logic [3:0] cmd, next_cmd;
    logic [memory_bits_wide-1:0] wbuf, next_wbuf;
    logic [31:0] rd_word, next_rd_word;
    logic bv, next_bv, rv, next_rv, rl, next_rl, ack, next_ack, act, next_act;
    logic aw_rdy, next_aw_rdy, ar_rdy, next_ar_rdy, w_rdy, next_w_rdy;
    logic [31:0] prd, next_prd;
    logic prdy, next_prdy;
    logic [9:0] pidx;
    logic dqs_valid;

    // Only [11:2] choose a register
    assign pidx = i_paddr[`DMCPS_APB_IDX_MSB:`DMCPS_APB_IDX_LSB];
    // Strobes only count on DDR parts
    assign dqs_valid = mem_is_ddr ? |(dqs_s2 & ~dqsn_s2) : 1'b1;

    // Next-state logic; cache/prot inputs feed nothing
    always_comb begin
        next_state = state;
        next_tag = tag;
        next_row = row;
        next_beats = beats;
        next_excl = excl;
        next_ref_cnt = ref_cnt + 10'h001;
        next_ref_due = ref_due;
        next_scratch = scratch;
        next_lp_en = lp_en;
        next_cmd = {1'b0, `DMCPS_CMD_NOP};
        next_wbuf = wbuf;
        next_rd_word = rd_word;
        next_bv = bv;
        next_rv = rv;
        next_rl = rl;
        next_aw_rdy = 1'b0;
        next_ar_rdy = 1'b0;
        next_w_rdy = 1'b0;
        next_prd = prd;
        next_prdy = 1'b0;
        // Refresh timer; a stalled read holds off refresh
        if (ref_cnt == REF_CYC - 10'h001) begin
            next_ref_cnt = 10'h000;
            next_ref_due = 1'b1;
        end
        unique case (state)
            DMCPS_IDLE: begin
                if (ref_due) begin
                    next_state = DMCPS_REF;
                end else if (i_awvalid && !aw_rdy && ack) begin
                    next_aw_rdy = 1'b1;
                    next_tag = i_awid;
                    next_row = i_awaddr[`DMCPS_ROW_MSB:`DMCPS_ROW_LSB];
                    next_excl = i_awlock == `DMCPS_LOCK_EXCL;
                    next_state = DMCPS_ACT;
                    next_beats = 4'h0;
                end else if (i_arvalid && !ar_rdy && ack) begin
                    next_ar_rdy = 1'b1;
                    next_tag = i_arid;
                    next_row = i_araddr[`DMCPS_ROW_MSB:`DMCPS_ROW_LSB];
                    next_excl = i_arlock == `DMCPS_LOCK_EXCL;
                    next_beats = i_arlen;
                    next_state = DMCPS_ACT;
                    next_rl = 1'b0;
                end
            end
            DMCPS_ACT: begin
                next_cmd = {1'b0, `DMCPS_CMD_ACT};
                next_state = (beats == 4'h0 && aw_rdy) ? DMCPS_WR : DMCPS_RD;
                if (aw_rdy) next_state = DMCPS_WR;
            end
            DMCPS_WR: begin
                next_w_rdy = !(i_wvalid && w_rdy && i_wlast);
                if (i_wvalid && w_rdy) begin
                    next_cmd = {1'b1, `DMCPS_CMD_WR};
                    next_wbuf = i_wdata[memory_bits_wide-1:0];
                    if (i_wlast) begin
                        next_state = DMCPS_BRESP;
                        next_bv = 1'b1;
                    end
                end
            end
            DMCPS_BRESP: begin
                if (bv && i_bready) begin
                    next_bv = 1'b0;
                    next_state = DMCPS_IDLE;
                end
            end
            DMCPS_RD: begin
                if (!rv || i_rready) begin
                    if (rv && rl) begin
                        next_rv = 1'b0;
                        next_state = DMCPS_IDLE;
                    end else if (dqs_valid) begin
                        next_cmd = {1'b1, `DMCPS_CMD_RD};
                        next_rd_word = 32'(dq_s2);
                        next_rv = 1'b1;
                        next_rl = beats == 4'h0;
                        next_beats = beats - 4'h1;
                    end else begin
                        next_rv = 1'b0;
                    end
                end
            end
            DMCPS_REF: begin
                next_cmd = {1'b0, `DMCPS_CMD_REF};
                // A timer tick in this same cycle wins over the clear
                next_ref_due = ref_cnt == REF_CYC - 10'h001;
                next_state = DMCPS_IDLE;
            end
            default: next_state = DMCPS_IDLE;
        endcase
        // APB: completes in access phase, never errors
        if (i_psel && i_penable && !prdy) begin
            next_prdy = 1'b1;
            if (i_pwrite) begin
                if (pidx == `DMCPS_REG_SCRATCH) next_scratch = i_pwdata;
                if (pidx == `DMCPS_REG_CTRL) next_lp_en = i_pwdata[0];
            end else begin
                unique case (pidx)
                    `DMCPS_REG_SCRATCH: next_prd = scratch;
                    `DMCPS_REG_STATUS: next_prd = {29'h0, state};
                    `DMCPS_REG_CTRL: next_prd = {31'h0, lp_en};
                    default: next_prd = 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Low-power handshake
    // ----------------------------------------------------------------
    // Ack follows the request level; it drops only once idle and allowed
    always_comb begin
        next_ack = ack;
        if (csys_s2) next_ack = 1'b1;
        else if (state == DMCPS_IDLE && lp_en && !ref_due) next_ack = 1'b0;
        next_act = ack || state != DMCPS_IDLE || i_awvalid || i_arvalid;
    end

    // Registers for all state
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= DMCPS_IDLE;
            tag <= '0;
            row <= '0;
            beats <= '0;
            excl <= 1'b0;
            ref_cnt <= '0;
            ref_due <= 1'b0;
            scratch <= '0;
            lp_en <= 1'b1;
            cmd <= {1'b0, `DMCPS_CMD_NOP};
            wbuf <= '0;
            rd_word <= '0;
            bv <= 1'b0;
            rv <= 1'b0;
            rl <= 1'b0;
            ack <= 1'b1;
            act <= 1'b1;
            aw_rdy <= 1'b0;
            ar_rdy <= 1'b0;
            w_rdy <= 1'b0;
            prd <= '0;
            prdy <= 1'b0;
        end else begin
            state <= next_state;
            tag <= next_tag;
            row <= next_row;
            beats <= next_beats;
            excl <= next_excl;
            ref_cnt <= next_ref_cnt;
            ref_due <= next_ref_due;
            scratch <= next_scratch;
            lp_en <= next_lp_en;
            cmd <= next_cmd;
            wbuf <= next_wbuf;
            rd_word <= next_rd_word;
            bv <= next_bv;
            rv <= next_rv;
            rl <= next_rl;
            ack <= next_ack;
            act <= next_act;
            aw_rdy <= next_aw_rdy;
            ar_rdy <= next_ar_rdy;
            w_rdy <= next_w_rdy;
            prd <= next_prd;
            prdy <= next_prdy;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, from flops, from compares on cmd and state, or tied constants
    // ----------------------------------------------------------------
    assign o_awready = aw_rdy;
    assign o_arready = ar_rdy;
    assign o_wready = w_rdy;
    assign o_bvalid = bv;
    assign o_bid = tag;
    assign o_bresp = {1'b0, excl}; // Upper bit tied low
    assign o_rvalid = rv;
    assign o_rid = tag;
    assign o_rresp = {1'b0, excl};
    assign o_rdata = rd_word;
    assign o_rlast = rl;
    assign o_csysack = ack;
    assign o_cactive = act;
    assign o_prdata = prd;
    assign o_pready = prdy;
    assign o_pslverr = 1'b0;
    // Pad selection fixed at build; PHY mode reuses ports
    assign o_add = row;
    assign o_auto_precharge_flag = ~use_phy_pads & cmd[3];
    assign o_ba = row[1:0];
    assign {o_ras_n, o_cas_n, o_we_n} = cmd[2:0];
    assign o_cs_n = {chip_select_count{cmd[2:0] == `DMCPS_CMD_NOP}};
    // One shared or per-chip clock enable
    assign o_cke = cke_per_chip ? {chip_select_count{ack}} : {{(chip_select_count-1){1'b0}}, ack};
    assign o_clk_out = {chip_select_count{1'b0}};
    assign o_data_en = state == DMCPS_WR;
    assign o_dqm = {MB{1'b0}};
    assign o_dq_out = wbuf;
    assign o_dqs_out = {MB{mem_is_ddr & cmd[3]}};

    // Assertions
    resp_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !o_bresp[1] && !o_rresp[1]) else $error("response upper bit set");
    apb_err_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !o_pslverr) else $error("apb error raised");
    apb_ready_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_psel && i_penable && !o_pready |=> o_pready) else $error("apb not ready");
    tag_echo_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_awvalid && o_awready |=> o_bid == $past(i_awid)) else $error("tag mismatch");
    rid_echo_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_arvalid && o_arready |=> o_rid == $past(i_arid)) else $error("read tag mismatch");
    lp_ack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !o_csysack |-> !csys_s2 || $past(!csys_s2)) else $error("ack without request");
    cke_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_cke[0] == o_csysack) else $error("cke wrong");
    bv_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bid)) else $error("bvalid dropped");
    dqs_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_dqs_out != '0 |-> mem_is_ddr && !o_cas_n) else $error("strobe on sdr");
endmodule

//--- testbench/dmcps_mem_model.sv
// Behavioural memory device facing the pad side of the controller
`timescale 1ns/100ps
module dmcps_mem_model #(
    parameter int bits_wide = 16,
    parameter bit is_ddr = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Command pads
    input wire logic i_cs_all_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    // Data pads
    input wire logic i_data_en,
    input wire logic [bits_wide-1:0] i_dq_out,
    output logic [bits_wide-1:0] o_dq_in,
    output logic [bits_wide/8-1:0] o_dqs_in,
    output logic [bits_wide/8-1:0] o_dqs_in_n
);
    logic [bits_wide-1:0] store;
    logic [3:0] rd_left;
    logic rd_cmd;

    // Read command: a chip selected, column strobe low, write enable high
    assign rd_cmd = !i_cs_all_n && i_ras_n && !i_cas_n && i_we_n;
    assign o_dqs_in_n = ~o_dqs_in;

    // Data only valid in a read window; a released bus flips every cycle
    // so that a controller sampling too late never sees a stale match
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            store <= '0;
            rd_left <= '0;
            o_dq_in <= '0;
            o_dqs_in <= '0;
        end else begin
            if (i_data_en) begin
                store <= i_dq_out;
            end
            rd_left <= rd_cmd ? 4'h8 : (rd_left != 4'h0 ? rd_left - 4'h1 : 4'h0);
            o_dq_in <= (rd_left != 4'h0) ? store : ~o_dq_in;
            o_dqs_in <= is_ddr ? ~o_dqs_in : '0;
        end
    end
endmodule

//--- testbench/tb_dram_ctrl_port_shell.sv
// Self-checking bench for the memory controller port shell
`timescale 1ns/100ps
`include "dmcps_regs.svh"
module tb_dram_ctrl_port_shell;
    localparam int CHIPS = 2;
    localparam int MBW = 16;
    localparam int TAG = 4;
    typedef struct {
        logic [31:0] data;
        logic [TAG-1:0] id;
        logic [1:0] resp;
        logic last;
        logic use_data;
    } dmcps_note_s;
    logic i_clk, i_nrst, i_awvalid, i_wlast, i_wvalid, i_bready, i_arvalid, i_rready;
    logic i_csysreq, i_psel, i_penable, i_pwrite;
    logic [31:0] i_awaddr, i_wdata, i_araddr, i_paddr, i_pwdata, o_rdata, o_prdata;
    logic [TAG-1:0] i_awid, i_wid, i_arid, o_bid, o_rid;
    logic [3:0] i_awlen, i_awcache, i_arlen, i_arcache;
    logic [1:0] i_awlock, i_arlock, o_bresp, o_rresp, o_ba;
    logic [2:0] i_awprot, i_arprot;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rlast, o_rvalid, o_csysack, o_cactive;
    logic o_pready, o_pslverr, o_auto_precharge_flag, o_ras_n, o_cas_n, o_we_n, o_data_en;
    logic [15:0] o_add;
    logic [CHIPS-1:0] o_cs_n, o_cke, o_clk_out;
    logic [MBW/8-1:0] o_dqm, o_dqs_out, i_dqs_in, i_dqs_in_n;
    logic [MBW-1:0] o_dq_out, i_dq_in;
    dmcps_note_s pq[$], bq[$], rq[$], n;
    int errors = 0;
    int checks_done = 0;
    integer seed = 58;

    dmcps_top #(.chip_select_count(CHIPS), .memory_bits_wide(MBW), .axi_tag_width(TAG),
        .use_phy_pads(1'b0), .cke_per_chip(1'b1), .mem_is_ddr(1'b1)) i_dmcps_top (
        .i_clk, .i_nrst, .i_awaddr, .i_awid, .i_awlen, .i_awlock, .i_awcache, .i_awprot,
        .i_awvalid, .o_awready, .i_wdata, .i_wid, .i_wlast, .i_wvalid, .o_wready, .o_bid,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arid, .i_arlen, .i_arlock, .i_arcache,
        .i_arprot, .i_arvalid, .o_arready, .o_rdata, .o_rid, .o_rlast, .o_rresp, .o_rvalid,
        .i_rready, .i_csysreq, .o_csysack, .o_cactive, .i_paddr, .i_psel, .i_penable,
        .i_pwrite, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_add,
        .o_auto_precharge_flag, .o_ba, .o_ras_n, .o_cas_n, .o_we_n, .o_cs_n, .o_cke,
        .o_clk_out, .o_data_en, .o_dqm, .o_dq_out, .i_dq_in, .i_dqs_in, .i_dqs_in_n,
        .o_dqs_out);

    dmcps_mem_model #(.bits_wide(MBW), .is_ddr(1'b1)) i_dmcps_mem_model (
        .i_clk, .i_nrst, .i_cs_all_n(&o_cs_n), .i_ras_n(o_ras_n), .i_cas_n(o_cas_n),
        .i_we_n(o_we_n), .i_data_en(o_data_en), .i_dq_out(o_dq_out), .o_dq_in(i_dq_in),
        .o_dqs_in(i_dqs_in), .o_dqs_in_n(i_dqs_in_n));

    always #50 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // Comparison and verdict
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic ready_of(input int w);
        case (w)
            0: ready_of = o_awready;
            1: ready_of = o_wready;
            2: ready_of = o_arready;
            default: ready_of = o_pready;
        endcase
    endfunction

    // Hold the request until its ready is seen at a rising edge, bounded
    task automatic hold_until(input int w);
        int k;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (ready_of(w) !== 1'b1 && k < 400);
        if (k >= 400) begin
            check("handshake timeout", 32'(w), 32'hffffffff);
            report_and_stop();
        end
    endtask

    // ------------------------------------------------------------
    // Drivers: each notes the answer it expects
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        dmcps_note_s e;
        @(negedge i_clk);
        i_paddr = {20'($random(seed)), idx, 2'($random(seed))}; // Junk outside index
        i_pwrite = wr;
        i_pwdata = d;
        i_psel = 1'b1;
        i_penable = 1'b0;
        e = '{data: d, id: '0, resp: 2'h0, last: 1'b0, use_data: !wr};
        pq.push_back(e);
        @(negedge i_clk);
        i_penable = 1'b1;
        hold_until(3);
        @(negedge i_clk);
        i_psel = 1'b0;
        i_penable = 1'b0;
    endtask

    task automatic axi_write(input logic [3:0] len);
        dmcps_note_s e;
        @(negedge i_clk);
        i_awaddr = $random(seed);
        i_awid = TAG'($random(seed));
        i_awlen = len;
        i_awlock = {1'b0, 1'($random(seed))};
        i_awcache = 4'($random(seed)); // Attributes vary and must not matter
        i_awprot = 3'($random(seed));
        i_awvalid = 1'b1;
        e = '{data: 32'h0, id: i_awid, resp: {1'b0, i_awlock == `DMCPS_LOCK_EXCL}, last: 1'b1,
            use_data: 1'b0};
        bq.push_back(e);
        hold_until(0);
        @(negedge i_clk);
        i_awvalid = 1'b0;
        for (int b = 0; b <= int'(len); b++) begin
            i_wdata = $random(seed);
            i_wid = i_awid;
            i_wlast = (b == int'(len));
            i_wvalid = 1'b1;
            hold_until(1);
            @(negedge i_clk);
        end
        i_wvalid = 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] len);
        dmcps_note_s e;
        @(negedge i_clk);
        i_araddr = $random(seed);
        i_arid = TAG'($random(seed));
        i_arlen = len;
        i_arlock = {1'b0, 1'($random(seed))};
        i_arcache = 4'($random(seed)); // Attributes vary and must not matter
        i_arprot = 3'($random(seed));
        i_arvalid = 1'b1;
        for (int b = 0; b <= int'(len); b++) begin
            e = '{data: 32'h0, id: i_arid, resp: {1'b0, i_arlock == `DMCPS_LOCK_EXCL},
                last: (b == int'(len)), use_data: 1'b0};
            rq.push_back(e);
        end
        hold_until(2);
        @(negedge i_clk);
        i_arvalid = 1'b0;
    endtask

    task automatic wait_ack(input logic lvl);
        for (int k = 0; k < 400 && o_csysack !== lvl; k++) @(posedge i_clk);
        check("csysack", 32'(o_csysack), 32'(lvl));
        if (o_csysack !== lvl) report_and_stop();
    endtask

    // Response stalls stay short, well inside one refresh period
    always @(negedge i_clk) begin
        if (i_nrst) begin
            i_bready = 1'($random(seed));
            i_rready = 1'($random(seed));
        end
    end

    // ------------------------------------------------------------
    // Watcher: oldest note against each answer
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_nrst && i_psel && o_pready === 1'b1) begin
            n = pq.pop_front();
            check("pslverr", 32'(o_pslverr), 32'h0);
            if (n.use_data) check("prdata", o_prdata, n.data);
        end
        if (i_nrst && i_bready && o_bvalid === 1'b1) begin
            n = bq.pop_front();
            check("bid", 32'(o_bid), 32'(n.id));
            check("bresp", 32'(o_bresp), 32'(n.resp));
        end
        if (i_nrst && i_rready && o_rvalid === 1'b1) begin
            n = rq.pop_front();
            check("rid", 32'(o_rid), 32'(n.id));
            check("rresp", 32'(o_rresp), 32'(n.resp));
            check("rlast", 32'(o_rlast), 32'(n.last));
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        {i_clk, i_nrst, i_awvalid, i_wlast, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {i_psel, i_penable, i_pwrite, i_awaddr, i_wdata, i_araddr, i_paddr, i_pwdata} = '0;
        {i_awid, i_wid, i_arid, i_awlen, i_awcache, i_arlen, i_arcache} = '0;
        {i_awlock, i_arlock, i_awprot, i_arprot} = '0;
        i_csysreq = 1'b1;
        repeat (5) @(negedge i_clk);
        check("cactive in reset", 32'(o_cactive), 32'h1);
        check("cke in reset", 32'(o_cke), 32'h3);
        check("cs width", 32'($bits(o_cs_n)), 32'(CHIPS));
        check("clk width", 32'($bits(o_clk_out)), 32'(CHIPS));
        check("dqm width", 32'($bits(o_dqm)), 32'(MBW / 8));
        check("dq width", 32'($bits(i_dq_in)), 32'(MBW));
        check("strobe width", 32'($bits(o_dqs_out)), 32'(MBW / 8));
        check("tag width", 32'($bits(o_rid)), 32'($bits(i_wid)));
        i_nrst = 1'b1;
        wait_ack(1'b1);
        apb(1'b0, `DMCPS_REG_CTRL, 32'h1);
        for (int t = 0; t < 4; t++) begin
            d = $random(seed);
            apb(1'b1, `DMCPS_REG_SCRATCH, d);
            apb(1'b0, `DMCPS_REG_SCRATCH, d);
        end
        axi_write(4'hf);
        axi_read(4'hf);
        for (int t = 0; t < 8; t++) begin
            axi_write(4'($random(seed)) & 4'h3);
            axi_read(4'($random(seed)) & 4'h3);
        end
        for (int k = 0; k < 3000 && (bq.size() + rq.size() + pq.size()) != 0; k++) begin
            @(posedge i_clk);
        end
        check("pending answers", 32'(bq.size() + rq.size() + pq.size()), 32'h0);
        @(negedge i_clk);
        i_csysreq = 1'b0;
        wait_ack(1'b0);
        @(negedge i_clk);
        i_csysreq = 1'b1;
        wait_ack(1'b1);
        report_and_stop();
    end
endmodule
